// File: pkg/mdfm_regs.svh
// Constants for the motor driver fault monitor: timing counts and field codes.
// Assumes a 25 MHz core clock; included by the package and the design.
// How it works
// - Stepping: current below open-load level is candidate
// - Holding: current below trip level is candidate
// - Fault only after candidate persists past detection time
// - SPI: detect only with open-load enable set
// - Time select 30/60/120 ms; pin mode 60 ms
// - Open load pulls error low, latches flags
// - Report which winding opened
// - Pin mode: release per enable pin or pulse
// - Recovery select 1: release pin, keep flags
// - Recovery select 0: hold all until clear
// - Sleep exit or power cycle clears open load
// - Silent step: detect only while moving
// - Auto-torque: current to torque setting on fault
// - SPI: warning sets warning and thermal flags
// - Report select: warning also pulls error low
// - Warning flags clear when temperature drops
// - Shutdown disables bridge, pump, pulls error low
// - Recovery mode from enable pin or select bit
// - Latched shutdown resumes after a sleep pulse or a switch to retry mode
// - Retry resumes when cool; flags stay latched
// - Report supply reading, default code 01011b
// - Error output released after power-up, low on fault
`ifndef MDFM_REGS_SVH
`define MDFM_REGS_SVH
`define MDFM_CLK_HZ        25000000
`define MDFM_OLT_30_MS     30
`define MDFM_OLT_60_MS     60
`define MDFM_OLT_120_MS    120
`define MDFM_MS_CYC(ms)    ((ms) * (`MDFM_CLK_HZ / 1000))
`define MDFM_OLT_30        2'h0
`define MDFM_OLT_60        2'h1
`define MDFM_OLT_120       2'h2
`define MDFM_OLT_RST       2'h1
`define MDFM_VM_RST        5'h0B
`define MDFM_SLP_MIN_US    20
`define MDFM_SLP_MAX_US    40
`define MDFM_SLP_MIN_CYC   ((`MDFM_SLP_MIN_US * (`MDFM_CLK_HZ / 1000000)) + 1)
`define MDFM_SLP_MAX_CYC   (`MDFM_SLP_MAX_US * (`MDFM_CLK_HZ / 1000000))
`define MDFM_CNT_W         23
`endif

// File: pkg/mdfm_pkg.sv
// Types for the motor driver fault monitor.
// Assumes mdfm_regs.svh sits beside it on the include path.
`include "mdfm_regs.svh"
package mdfm_pkg;
  // Configuration bits set by software or pins
  typedef struct packed {
    logic       spi_mode;
    logic       open_load_enable;
    logic [1:0] open_load_time_select;
    logic       open_load_recovery_select;
    logic       warning_report_select;
    logic       thermal_recovery_select;
    logic       enable_high;
    logic       silent_step;
    logic       auto_torque;
  } mdfm_cfg_s;
  // Status bits read back
  typedef struct packed {
    logic fault;
    logic open_load_flag;
    logic winding_a_open;
    logic winding_b_open;
    logic overtemp_warning;
    logic thermal_flag;
    logic shutdown_thermal_flag;
  } mdfm_stat_s;
  typedef enum logic [2:0] {
    MDFM_RUN  = 3'h1,
    MDFM_HOT  = 3'h2,
    MDFM_COOL = 3'h4
  } mdfm_tsd_e;
endpackage

// File: design/mdfm_fault_monitor.sv
// Fault supervision: open load, over-temperature warning and shutdown,
// supply reading, open-drain error output.
// Assumes comparator inputs already synchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none
`include "mdfm_regs.svh"
module mdfm_fault_monitor
  import mdfm_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire mdfm_cfg_s  cfg_i,
  input  wire logic       sleep_n_i,
  input  wire logic       clear_faults_cmd_i,
  input  wire logic       moving_i,
  input  wire logic [1:0] below_ol_level_i,
  input  wire logic [1:0] below_trip_level_i,
  input  wire logic       temp_warn_i,
  input  wire logic       temp_warn_clear_i,
  input  wire logic       temp_sd_i,
  input  wire logic       temp_sd_clear_i,
  input  wire logic [4:0] adc_code_i,
  input  wire logic       adc_valid_i,
  output var  mdfm_stat_s stat_o,
  output logic [4:0]      supply_voltage_reading_o,
  output logic            bridge_enable_o,
  output logic            charge_pump_enable_o,
  output logic            torque_current_select_o,
  output logic            error_out_n_o,
  output logic            error_out_n_oe_o
);
  // ----------------------------------------
  // Sleep reset pulse and sleep exit
  // ----------------------------------------
  logic [10:0] slp_cnt_reg, slp_cnt_next;
  logic        sleep_d_reg, sleep_d_next;
  logic        slp_pulse, slp_exit;
  // A low of more than 20 us counts as a reset pulse; longer also clears
  always_comb begin
    slp_cnt_next = sleep_n_i ? 11'h000 :
                   (slp_cnt_reg == 11'h7FF ? slp_cnt_reg : slp_cnt_reg + 11'h001);
    sleep_d_next = sleep_n_i;
  end
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      slp_cnt_reg <= 11'h000;
      sleep_d_reg <= 1'b1;
    end else begin
      slp_cnt_reg <= slp_cnt_next;
      sleep_d_reg <= sleep_d_next;
    end
  end
  assign slp_pulse = sleep_n_i && !sleep_d_reg
                     && (slp_cnt_reg >= 11'(`MDFM_SLP_MIN_CYC));
  // Any low of the pin ends a sleep, even one shorter than the reset pulse
  assign slp_exit  = sleep_n_i && !sleep_d_reg;
  logic clr_all;
  // The clear command only exists over SPI; pin mode clears by sleep pulse alone
  assign clr_all = (cfg_i.spi_mode && clear_faults_cmd_i) || slp_exit || slp_pulse;

  // ----------------------------------------
  // Open-load detection per winding
  // ----------------------------------------
  logic [`MDFM_CNT_W-1:0] ol_limit;
  always_comb begin
    if (!cfg_i.spi_mode) ol_limit = `MDFM_CNT_W'(`MDFM_MS_CYC(`MDFM_OLT_60_MS));
    else begin
      case (cfg_i.open_load_time_select)
        `MDFM_OLT_30:  ol_limit = `MDFM_CNT_W'(`MDFM_MS_CYC(`MDFM_OLT_30_MS));
        `MDFM_OLT_120: ol_limit = `MDFM_CNT_W'(`MDFM_MS_CYC(`MDFM_OLT_120_MS));
        default:       ol_limit = `MDFM_CNT_W'(`MDFM_MS_CYC(`MDFM_OLT_60_MS));
      endcase
    end
  end
  logic ol_allowed;
  // Silent step cannot see open load at standstill
  assign ol_allowed = (!cfg_i.spi_mode || cfg_i.open_load_enable)
                      && !(cfg_i.silent_step && !moving_i);
  logic [1:0] cand, ol_det, ol_lat_reg, ol_lat_next, ol_pin_reg, ol_pin_next;
  genvar w;
  generate
    for (w = 0; w < 2; w = w + 1) begin : g_win
      logic [`MDFM_CNT_W-1:0] cnt_reg, cnt_next;
      assign cand[w] = ol_allowed && (moving_i ? below_ol_level_i[w]
                                               : below_trip_level_i[w]);
      // Counter restarts on any break so only a continuous condition counts
      always_comb begin
        if (!cand[w]) cnt_next = '0;
        else if (cnt_reg > ol_limit) cnt_next = cnt_reg;
        else cnt_next = cnt_reg + `MDFM_CNT_W'(1);
      end
      always_ff @(posedge clk_i) begin
        if (!rst_n_i) cnt_reg <= '0;
        else cnt_reg <= cnt_next;
      end
      assign ol_det[w] = cnt_reg > ol_limit;
      a_ol_persist: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $rose(ol_det[w]) |-> $past(cand[w]))
        else $error("open load declared without candidate");
    end
  endgenerate
  logic ol_latched_pin;
  assign ol_latched_pin = cfg_i.spi_mode ? !cfg_i.open_load_recovery_select : !cfg_i.enable_high;
  // Status bits latch; detection wins over a clear in the same cycle
  always_comb begin
    ol_lat_next = clr_all ? (ol_lat_reg & 2'h0) | ol_det : ol_lat_reg | ol_det;
    // Pin hold: auto modes follow detection, latched modes hold to clear
    if (ol_latched_pin) ol_pin_next = (clr_all ? 2'h0 : ol_pin_reg) | ol_det;
    else ol_pin_next = ol_det;
  end
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ol_lat_reg <= 2'h0;
      ol_pin_reg <= 2'h0;
    end else begin
      ol_lat_reg <= ol_lat_next;
      ol_pin_reg <= ol_pin_next;
    end
  end

  // ----------------------------------------
  // Thermal warning and shutdown
  // ----------------------------------------
  logic      otw_reg, otw_next, tf_lat_reg, tf_lat_next, ots_reg, ots_next;
  mdfm_tsd_e tsd_reg, tsd_next;
  logic      tsd_latched;
  assign tsd_latched = cfg_i.spi_mode ? !cfg_i.thermal_recovery_select : !cfg_i.enable_high;
  always_comb begin
    // Warning has hysteresis in the comparator pair, no command needed
    if (temp_warn_i && cfg_i.spi_mode) otw_next = 1'b1;
    else if (temp_warn_clear_i) otw_next = 1'b0;
    else otw_next = otw_reg;
    tsd_next = tsd_reg;
    case (tsd_reg)
      MDFM_RUN:  if (temp_sd_i) tsd_next = MDFM_HOT;
      MDFM_HOT:  if (temp_sd_clear_i && !temp_sd_i) tsd_next = tsd_latched ? MDFM_COOL : MDFM_RUN;
      MDFM_COOL: begin
        // A fresh overheat while waiting must not let a mode change restart the bridge
        if (temp_sd_i) tsd_next = MDFM_HOT;
        else if (!tsd_latched) tsd_next = MDFM_RUN;
        else if (slp_pulse || slp_exit) tsd_next = MDFM_RUN;
      end
      default: tsd_next = MDFM_RUN;
    endcase
    tf_lat_next = (temp_sd_i && cfg_i.spi_mode) || (!clr_all && tf_lat_reg);
    ots_next    = (temp_sd_i && cfg_i.spi_mode) || (!clr_all && ots_reg);
  end
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      otw_reg    <= 1'b0;
      tf_lat_reg <= 1'b0;
      ots_reg    <= 1'b0;
      tsd_reg    <= MDFM_RUN;
    end else begin
      otw_reg    <= otw_next;
      tf_lat_reg <= tf_lat_next;
      ots_reg    <= ots_next;
      tsd_reg    <= tsd_next;
    end
  end
  logic tsd_off;
  assign tsd_off = tsd_reg != MDFM_RUN;
  assign bridge_enable_o      = !tsd_off;
  assign charge_pump_enable_o = !tsd_off;

  // ----------------------------------------
  // Summary, supply reading, error pin
  // ----------------------------------------
  logic fault_reg, fault_next, err_reg, err_next, trq_reg, trq_next;
  logic [4:0] vm_reg, vm_next;
  logic warn_rep;
  assign warn_rep = otw_reg && cfg_i.warning_report_select;
  always_comb begin
    fault_next = (cfg_i.spi_mode && (|ol_det || warn_rep || temp_sd_i))
                 || (!clr_all && fault_reg);
    err_next   = |ol_pin_reg || warn_rep || tsd_reg == MDFM_HOT
                 || tsd_reg == MDFM_COOL;
    trq_next   = cfg_i.auto_torque && |ol_pin_reg;
    vm_next    = adc_valid_i ? adc_code_i : vm_reg;
  end
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      fault_reg <= 1'b0;
      err_reg   <= 1'b0;
      trq_reg   <= 1'b0;
      vm_reg    <= `MDFM_VM_RST;
    end else begin
      fault_reg <= fault_next;
      err_reg   <= err_next;
      trq_reg   <= trq_next;
      vm_reg    <= vm_next;
    end
  end
  // Open drain: only ever drive low; pull-up makes the high
  assign error_out_n_o    = 1'b0;
  assign error_out_n_oe_o = err_reg;
  assign supply_voltage_reading_o = vm_reg;
  assign torque_current_select_o  = trq_reg;
  assign stat_o.fault                 = fault_reg;
  assign stat_o.open_load_flag        = |ol_lat_reg && cfg_i.spi_mode;
  assign stat_o.winding_a_open        = ol_lat_reg[0] && cfg_i.spi_mode;
  assign stat_o.winding_b_open        = ol_lat_reg[1] && cfg_i.spi_mode;
  assign stat_o.overtemp_warning      = otw_reg;
  assign stat_o.thermal_flag          = otw_reg || tf_lat_reg;
  assign stat_o.shutdown_thermal_flag = ots_reg;

  a_err_follows_ol: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    |ol_det |-> ##2 error_out_n_oe_o)
    else $error("error pin not driven after open load");
  a_tsd_bridge_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    temp_sd_i |=> !bridge_enable_o && !charge_pump_enable_o
                  && (stat_o.shutdown_thermal_flag || !cfg_i.spi_mode))
    else $error("shutdown did not disable bridge");
  a_latch_holds_low: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    tsd_reg == MDFM_COOL && tsd_latched && sleep_n_i && sleep_d_reg |=> !bridge_enable_o)
    else $error("latched shutdown resumed without pulse");
  a_warn_clears: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    temp_warn_clear_i && !temp_warn_i |=> !stat_o.overtemp_warning)
    else $error("warning did not clear");
  a_ol_gate: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cfg_i.spi_mode && !cfg_i.open_load_enable |-> cand == 2'h0)
    else $error("open load candidate while disabled");
  a_silent_still: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cfg_i.silent_step && !moving_i |-> cand == 2'h0)
    else $error("open load candidate at standstill");
  a_ol_flag_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    stat_o.winding_a_open && !clr_all && cfg_i.spi_mode |=> ol_lat_reg[0])
    else $error("open load flag dropped without clear");
  a_warn_report: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    warn_rep |=> error_out_n_oe_o && (fault_reg || !cfg_i.spi_mode))
    else $error("warning not reported on error pin");
endmodule
`default_nettype wire

// File: tb/mdfm_host_model.sv
// Host-side model: drives the sleep pin and the clear-fault command.
// Assumes its tasks are called from falling-edge stimulus.
`timescale 1ns/1ps
`default_nettype none
module mdfm_host_model (
  input  wire logic clk_i,
  output logic      sleep_n_o,
  output logic      clear_faults_cmd_o
);
  // --------------------------------------------------------------
  // Pin drivers
  // --------------------------------------------------------------
  // Both pins are push-pull, so idle levels are plain constants
  initial begin
    sleep_n_o          = 1'b1;
    clear_faults_cmd_o = 1'b0;
  end
  // Keep the low time inside 20 to 40 us, or the device may also shut down
  task automatic pulse_sleep(input int cycles);
    sleep_n_o = 1'b0;
    repeat (cycles) @(negedge clk_i);
    sleep_n_o = 1'b1;
  endtask
  // One-cycle clear command
  task automatic clear_faults();
    clear_faults_cmd_o = 1'b1;
    @(negedge clk_i);
    clear_faults_cmd_o = 1'b0;
  endtask
endmodule
`default_nettype wire

// File: tb/motor_driver_fault_monitor_test.sv
// Self-checking bench for the fault monitor.
// Assumes the host model drives sleep and clear; all else comes from here.
`timescale 1ns/1ps
`default_nettype none
module motor_driver_fault_monitor_test;
  import mdfm_pkg::*;
  // --------------------------------------------------------------
  // Stimulus and wiring
  // --------------------------------------------------------------
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  mdfm_cfg_s  cfg = '0;
  logic       moving = 1'b0, warn = 1'b0, warn_clr = 1'b1, sd = 1'b0, sd_clr = 1'b1, adc_vld = 1'b0;
  logic [1:0] below_ol = 2'h0, below_trip = 2'h0;
  logic [4:0] adc = 5'h00;
  wire        sleep_n, clr_cmd, bridge, pump, trq, err_n, oe;
  wire [4:0]  vm;
  mdfm_stat_s stat, exp_s;
  int         mismatches = 0, check_count = 0, cycles = 0;

  mdfm_host_model host (.clk_i(clk), .sleep_n_o(sleep_n), .clear_faults_cmd_o(clr_cmd));
  mdfm_fault_monitor DUT (.clk_i(clk), .rst_n_i(rst_n), .cfg_i(cfg), .sleep_n_i(sleep_n),
    .clear_faults_cmd_i(clr_cmd), .moving_i(moving), .below_ol_level_i(below_ol),
    .below_trip_level_i(below_trip), .temp_warn_i(warn), .temp_warn_clear_i(warn_clr),
    .temp_sd_i(sd), .temp_sd_clear_i(sd_clr), .adc_code_i(adc), .adc_valid_i(adc_vld),
    .stat_o(stat), .supply_voltage_reading_o(vm), .bridge_enable_o(bridge),
    .charge_pump_enable_o(pump), .torque_current_select_o(trq), .error_out_n_o(err_n),
    .error_out_n_oe_o(oe));

  initial forever #20 clk = ~clk;
  // Hang guard: the tests need well under this many cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      end_of_test();
    end
  end
  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count = check_count + 1;
    if (seen !== exp) begin
      mismatches = mismatches + 1;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Heat past shutdown, cool down, then recover the way the mode demands
  task automatic thermal_case(input logic spi, input logic sel, input logic en, input logic retry);
    cfg = '0;
    cfg.spi_mode = spi;
    cfg.thermal_recovery_select = sel;
    cfg.enable_high = en;
    exp_s = '0;
    exp_s.fault = 1'b1;
    exp_s.thermal_flag = 1'b1;
    exp_s.shutdown_thermal_flag = 1'b1;
    sd = 1'b1;
    sd_clr = 1'b0;
    cyc(3);
    chk({bridge, pump, oe}, 8'h01);
    if (spi) chk(stat, exp_s);
    sd = 1'b0;
    sd_clr = 1'b1;
    cyc(3);
    chk({bridge, oe}, {retry, ~retry});
    if (spi) chk(stat, exp_s);
    if (!retry) begin
      host.pulse_sleep(600);
      cyc(3);
      chk({bridge, pump, oe}, 8'h06);
    end
    host.clear_faults();
    cyc(2);
    chk({stat, oe}, 8'h00);
    $display("thermal case spi=%0d sel=%0d en=%0d done", spi, sel, en);
  endtask
  // --------------------------------------------------------------
  // Tests
  // --------------------------------------------------------------
  initial begin
    cyc(5);
    rst_n = 1'b1;
    cyc(1);
    chk({stat, oe}, 8'h00);
    chk({bridge, pump, vm}, 8'h6B);
    chk(err_n, 8'h00);
    adc = 5'h13;
    adc_vld = 1'b1;
    cyc(1);
    adc_vld = 1'b0;
    cyc(1);
    chk(vm, 8'h13);
    $display("reset and supply test done");
    // Warning with reporting on, then auto clear, then ignored in pin mode
    cfg = '0;
    cfg.spi_mode = 1'b1;
    cfg.warning_report_select = 1'b1;
    warn = 1'b1;
    warn_clr = 1'b0;
    cyc(3);
    chk({stat.overtemp_warning, stat.thermal_flag, bridge, pump}, 8'h0F);
    chk({stat.fault, oe}, 8'h03);
    warn = 1'b0;
    warn_clr = 1'b1;
    cyc(2);
    chk({stat.overtemp_warning, stat.thermal_flag}, 8'h00);
    host.clear_faults();
    cfg.spi_mode = 1'b0;
    warn = 1'b1;
    warn_clr = 1'b0;
    cyc(3);
    chk({stat, oe}, 8'h00);
    warn = 1'b0;
    warn_clr = 1'b1;
    cyc(2);
    $display("warning test done");
    thermal_case(1'b1, 1'b1, 1'b0, 1'b1);
    thermal_case(1'b1, 1'b0, 1'b1, 1'b0);
    thermal_case(1'b0, 1'b0, 1'b1, 1'b1);
    thermal_case(1'b0, 1'b1, 1'b0, 1'b0);
    // Candidates while gated off, at silent-step standstill, then short ones held and stepping
    cfg = '0;
    cfg.spi_mode = 1'b1;
    cfg.auto_torque = 1'b1;
    below_ol = 2'h3;
    below_trip = 2'h3;
    cyc(4);
    chk({stat, oe}, 8'h00);
    cfg.open_load_enable = 1'b1;
    cfg.silent_step = 1'b1;
    cyc(4);
    chk({stat, oe}, 8'h00);
    // Detection takes far longer than the run, so only the no-fault side is seen here
    cfg.silent_step = 1'b0;
    cyc(2000);
    chk({stat, oe}, 8'h00);
    below_trip = 2'h0;
    moving = 1'b1;
    below_ol = 2'h1;
    cyc(2000);
    chk({stat, oe}, 8'h00);
    chk({trq, err_n}, 8'h00);
    below_ol = 2'h0;
    $display("open load persistence test done");
    end_of_test();
  end
endmodule
`default_nettype wire
